// [rxh_header_writer.sv]
// rxh_header_writer.sv: stores a received packet into its buffer and builds
// the eight-byte header in front of it.
// assumes: serial engine strobes are synchronous to mclk; the buffer RAM
// takes one byte write per cycle and never stalls.
`timescale 1ns/1ps
`default_nettype none
`include "rxh_regs.svh"

module rxh_header_writer
  import rxh_pkg::*;
#(
  parameter int EP_NUM      = 16,
  parameter int MAX_PAYLOAD = 1280
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  // serial engine packet side
  input  wire logic        pktStart,
  input  wire logic [3:0]  pktEndpoint,
  input  wire logic [3:0]  pktPid,
  input  wire logic [6:0]  receivedFunctionAddress,
  input  wire logic [15:0] pktFrame,
  input  wire logic        pktIso,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        pktEnd,
  input  wire logic        pktCrcErr,
  input  wire logic        receivedToggleBit,
  output logic             busy,
  // buffer RAM write port
  output logic             memWe,
  output logic      [10:0] memAddr,
  output logic      [7:0]  memData,
  output logic             memByDma,
  output logic             pktDone,
  // interrupt
  output logic             irq
);

  // ==========================================================
  // state
  localparam rxh_ofs_t CNT_MAX = 11'(MAX_PAYLOAD) + `RXH_HDR_LEN;

  rxh_state_t  state_q;
  rxh_ofs_t    cnt_q;
  logic [2:0]  hdrIdx_q;
  logic [3:0]  ep_q;
  logic [3:0]  pid_q;
  logic [6:0]  fadr_q;
  logic [15:0] frame_q;
  logic        iso_q;
  logic        tog_q;
  logic        crc_q;
  logic        mis_q;
  logic [EP_NUM-1:0] lastTog_q;
  logic [7:0]  ctrl_q;
  logic [3:0]  stat_q;
  logic [3:0]  mask_q;
  logic [10:0] lastCnt_q;
  logic        memWe_q;
  logic [10:0] memAddr_q;
  logic [7:0]  memData_q;
  logic        memByDma_q;
  logic        pktDone_q;
  logic [7:0]  regRdData_q;
  logic [7:0]  hdrByte;
  logic        togMatch;
  logic        startOk;
  logic        payWr;
  logic        payDrop;
  logic        togClr;
  logic        statRd;

  assign startOk  = (state_q == RXH_IDLE) && pktStart && ctrl_q[`RXH_CTRL_EN];
  assign payWr    = (state_q == RXH_PAY) && rxValid && (cnt_q < CNT_MAX);
  assign payDrop  = (state_q == RXH_PAY) && rxValid && (cnt_q >= CNT_MAX);
  assign togClr   = regWr && (regAddr == `RXH_REG_CTRL) &&
                    regWrData[`RXH_CTRL_TCLR];
  assign statRd   = regRd && (regAddr == `RXH_REG_STAT);
  assign togMatch = (receivedToggleBit == lastTog_q[ep_q]);

  assign busy      = (state_q != RXH_IDLE);
  assign memWe     = memWe_q;
  assign memAddr   = memAddr_q;
  assign memData   = memData_q;
  assign memByDma  = memByDma_q;
  assign pktDone   = pktDone_q;
  assign regRdData = regRdData_q;
  assign irq       = |(stat_q & mask_q);

  // ==========================================================
  // header byte contents
  always_comb begin
    hdrByte = `RXH_RSVD_VAL;
    case (hdrIdx_q)
      `RXH_OFS_STAT: begin
        hdrByte = {crc_q, tog_q, mis_q, 1'b0, ep_q}; // R03 R10 R11
      end
      `RXH_OFS_PID:   hdrByte = {4'h0, pid_q}; // R03
      `RXH_OFS_ADDR:  hdrByte = {1'b0, fadr_q}; // R03
      `RXH_OFS_RSVD:  hdrByte = `RXH_RSVD_VAL; // R04
      `RXH_OFS_FRMLO: hdrByte = frame_q[7:0]; // R04
      `RXH_OFS_FRMHI: hdrByte = frame_q[15:8]; // R04
      `RXH_OFS_CNTLO: hdrByte = cnt_q[7:0]; // R06 R13
      `RXH_OFS_CNTHI: hdrByte = {5'h00, cnt_q[10:8]}; // R06
      default:        hdrByte = `RXH_RSVD_VAL;
    endcase
  end

  // ==========================================================
  // sequence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q  <= RXH_IDLE;
      hdrIdx_q <= 3'h0;
    end else begin
      case (state_q)
        RXH_IDLE: begin
          hdrIdx_q <= 3'h0;
          if (startOk) begin
            state_q <= RXH_PAY;
          end
        end
        RXH_PAY: begin
          if (pktEnd) begin
            state_q <= RXH_SIEH;
          end
        end
        RXH_SIEH: begin
          hdrIdx_q <= hdrIdx_q + 3'h1;
          if (hdrIdx_q == `RXH_OFS_FRMHI) begin
            state_q <= RXH_DMAH; // R05
          end
        end
        RXH_DMAH: begin
          hdrIdx_q <= hdrIdx_q + 3'h1;
          if (hdrIdx_q == `RXH_OFS_CNTHI) begin
            state_q <= RXH_IDLE;
          end
        end
        default: begin
          state_q <= RXH_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // packet fields captured at start and end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ep_q    <= 4'h0;
      pid_q   <= 4'h0;
      fadr_q  <= 7'h00;
      frame_q <= 16'h0000;
      iso_q   <= 1'b0;
    end else if (startOk) begin
      ep_q    <= pktEndpoint;
      pid_q   <= pktPid;
      fadr_q  <= receivedFunctionAddress;
      frame_q <= pktFrame;
      iso_q   <= pktIso;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tog_q <= 1'b0;
      crc_q <= 1'b0;
      mis_q <= 1'b0;
    end else if ((state_q == RXH_PAY) && pktEnd) begin
      tog_q <= receivedToggleBit; // R10
      crc_q <= pktCrcErr; // R11
      mis_q <= !iso_q && togMatch; // R07 R08 R09
    end
  end

  // last toggle per endpoint, only non-isochronous good packets count
  for (genvar e = 0; e < EP_NUM; e++) begin : gTog
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        lastTog_q[e] <= `RXH_TOG_RST;
      end else if (togClr) begin
        lastTog_q[e] <= `RXH_TOG_RST;
      end else if ((state_q == RXH_DMAH) && (hdrIdx_q == `RXH_OFS_CNTHI) &&
                   !iso_q && !crc_q && (ep_q == 4'(e))) begin
        lastTog_q[e] <= tog_q; // R08
      end
    end
  end

  // ==========================================================
  // offset counter: ends as payload length plus eight, held at CNT_MAX for longer payloads
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= `RXH_HDR_LEN;
    end else if (startOk) begin
      cnt_q <= `RXH_HDR_LEN; // R02
    end else if (payWr) begin
      cnt_q <= cnt_q + 11'h001; // R02 R13
    end
  end

  // ==========================================================
  // buffer write port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      memWe_q    <= 1'b0;
      memAddr_q  <= 11'h000;
      memData_q  <= 8'h00;
      memByDma_q <= 1'b0;
    end else if (payWr) begin
      memWe_q    <= 1'b1;
      memAddr_q  <= cnt_q; // R02
      memData_q  <= rxData;
      memByDma_q <= 1'b0;
    end else if ((state_q == RXH_SIEH) || (state_q == RXH_DMAH)) begin
      memWe_q    <= 1'b1;
      memAddr_q  <= {8'h00, hdrIdx_q}; // R01
      memData_q  <= hdrByte;
      memByDma_q <= (state_q == RXH_DMAH); // R05
    end else begin
      memWe_q    <= 1'b0;
      memByDma_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pktDone_q <= 1'b0;
      lastCnt_q <= 11'h000;
    end else begin
      pktDone_q <= (state_q == RXH_DMAH) && (hdrIdx_q == `RXH_OFS_CNTHI);
      if ((state_q == RXH_DMAH) && (hdrIdx_q == `RXH_OFS_CNTHI)) begin
        lastCnt_q <= cnt_q; // R13
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `RXH_CTRL_RST;
      mask_q <= `RXH_MASK_RST;
    end else if (regWr) begin
      if (regAddr == `RXH_REG_CTRL) begin
        ctrl_q <= {7'h00, regWrData[`RXH_CTRL_EN]};
      end else if (regAddr == `RXH_REG_MASK) begin
        mask_q <= regWrData[3:0];
      end
    end
  end

  // sticky events; a new event beats the clearing read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (statRd ? 4'h0 : stat_q) |
                {payDrop,
                 pktDone_q && mis_q,
                 pktDone_q && crc_q,
                 pktDone_q};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdData_q <= 8'h00;
    end else if (regRd) begin
      if (regAddr == `RXH_REG_CTRL) begin
        regRdData_q <= ctrl_q;
      end else if (regAddr == `RXH_REG_STAT) begin
        regRdData_q <= {4'h0, stat_q};
      end else if (regAddr == `RXH_REG_MASK) begin
        regRdData_q <= {4'h0, mask_q};
      end else if (regAddr == `RXH_REG_CNTLO) begin
        regRdData_q <= lastCnt_q[7:0];
      end else if (regAddr == `RXH_REG_CNTHI) begin
        regRdData_q <= {5'h00, lastCnt_q[10:8]};
      end else begin
        regRdData_q <= 8'h00;
      end
    end else begin
      regRdData_q <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  hdr_window_a: assert property ( // R01
    $past((state_q == RXH_SIEH) || (state_q == RXH_DMAH)) |->
      memWe && (memAddr < `RXH_HDR_LEN))
    else $error("header write outside bytes zero to seven");

  payload_order_a: assert property ( // R02
    payWr |=> memWe && (memAddr == $past(cnt_q)) &&
              (memData == $past(rxData)) && (memAddr >= `RXH_HDR_LEN))
    else $error("payload byte not stored at its offset");

  byte_ids_a: assert property ( // R03
    memWe && !memByDma && (memAddr == 11'h001) |->
      (memData == {4'h0, pid_q}) && !$past(memByDma))
    else $error("packet id byte malformed");

  byte_addr_a: assert property ( // R03
    memWe && (memAddr == 11'h002) && (state_q == RXH_SIEH) |->
      memData == {1'b0, fadr_q})
    else $error("function address byte malformed");

  frame_bytes_a: assert property ( // R04
    memWe && (memAddr == 11'h004) && !memByDma |->
      (memData == frame_q[7:0]) ##1 memWe && (memAddr == 11'h005) &&
      (memData[2:0] == frame_q[10:8]) && (memData[7:3] == frame_q[15:11]))
    else $error("frame count bytes malformed");

  dma_owner_a: assert property ( // R05
    memWe && (memAddr == 11'h005) && !memByDma |->
      ##1 memWe && memByDma && (memAddr == 11'h006)
      ##1 memWe && memByDma && (memAddr == 11'h007) && pktDone
      ##1 !pktDone)
    else $error("count bytes not written by the DMA engine");

  count_bytes_a: assert property ( // R06
    memWe && memByDma && (memAddr == 11'h007) |->
      (memData[7:3] == 5'h00) && (memData[2:0] == cnt_q[10:8]) &&
      ($past(memData) == cnt_q[7:0]))
    else $error("byte count bytes malformed");

  toggle_flag_a: assert property ( // R07
    memWe && !memByDma && (memAddr == 11'h000) |->
      memData[`RXH_B0_MIS] ==
        (!iso_q && (tog_q == lastTog_q[ep_q]))) // R08 R09
    else $error("toggle mismatch flag wrong");

  iso_no_flag_a: assert property ( // R09
    memWe && !memByDma && (memAddr == 11'h000) && iso_q |->
      !memData[`RXH_B0_MIS])
    else $error("mismatch flagged on isochronous packet");

  toggle_crc_a: assert property ( // R10
    (state_q == RXH_PAY) && pktEnd |=>
      ##1 memWe && (memAddr == 11'h000) &&
      (memData[`RXH_B0_TOG] == $past(receivedToggleBit, 2)) &&
      (memData[`RXH_B0_CRC] == $past(pktCrcErr, 2)) && // R11
      (memData[3:0] == ep_q) && !memData[4])
    else $error("status byte does not match packet end");

  count_len_a: assert property ( // R13
    pktDone |-> memWe && memByDma && (memAddr == 11'h007) &&
      (lastCnt_q == cnt_q) && (lastCnt_q >= `RXH_HDR_LEN))
    else $error("byte count is not payload plus eight");

endmodule // rxh_header_writer

`default_nettype wire

// [rxh_header_writer_tb_top.sv]
// rxh_header_writer_tb_top.sv: self-checking bench for the header writer.
// assumes: rxh_host_model drives the packet side; bench owns register port.
`timescale 1ns/1ps
`default_nettype none

module rxh_header_writer_tb_top;
  import rxh_pkg::*;

  typedef struct {
    logic [3:0] ep; logic [3:0] pid; logic [6:0] fa; logic [15:0] frm;
    logic iso; logic tog; logic crc; int len; logic mis;
  } rxh_row_t;

  logic        mclk, rst, regWr, regRd, busy, memWe, memByDma, pktDone, irq;
  logic [3:0]  regAddr, pktEndpoint, pktPid;
  logic [7:0]  regWrData, regRdData, rxData, memData, rd;
  logic [6:0]  receivedFunctionAddress;
  logic [15:0] pktFrame;
  logic        pktIso, rxValid, pktEnd, pktCrcErr, receivedToggleBit, irqExp;
  logic [10:0] memAddr;
  logic        pktStart, doneExp;
  logic [7:0]  pbuf [0:1535];
  int          miscompares, totalChecks, cycles;

`define CHK(nm, ex, gt) begin totalChecks++; if ((gt) !== (ex)) begin \
  miscompares++; $display("mismatch %s expected %h seen %h", nm, ex, gt); \
  end end

  rxh_header_writer i_rxh_header_writer (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .pktStart(pktStart), .pktEndpoint(pktEndpoint), .pktPid(pktPid),
    .receivedFunctionAddress(receivedFunctionAddress),
    .pktFrame(pktFrame), .pktIso(pktIso), .rxValid(rxValid),
    .rxData(rxData), .pktEnd(pktEnd), .pktCrcErr(pktCrcErr),
    .receivedToggleBit(receivedToggleBit), .busy(busy), .memWe(memWe),
    .memAddr(memAddr), .memData(memData), .memByDma(memByDma),
    .pktDone(pktDone), .irq(irq));
  rxh_host_model i_rxh_host_model (.mclk(mclk), .pktStart(pktStart),
    .pktEndpoint(pktEndpoint), .pktPid(pktPid), .pktFrame(pktFrame),
    .receivedFunctionAddress(receivedFunctionAddress), .pktIso(pktIso),
    .rxValid(rxValid), .rxData(rxData), .pktEnd(pktEnd),
    .pktCrcErr(pktCrcErr), .receivedToggleBit(receivedToggleBit));

  // ==========================================================
  // clock, buffer monitor, timeout
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    if (memWe === 1'b1) begin
      pbuf[memAddr] = memData;
      `CHK("memByDma", memAddr == 11'h006 || memAddr == 11'h007, memByDma)
    end
    doneExp = memWe === 1'b1 && memByDma === 1'b1 && memAddr == 11'h007;
    if (rst === 1'b0) `CHK("pktDone", doneExp, pktDone)
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      reportAndStop();
    end
  end

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // register port and packet tasks
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a; regWrData <= d; regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a; regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rd = regRdData;
  endtask

  task automatic sendWait(input rxh_row_t r);
    int n;
    for (int a = 0; a < 1536; a++) pbuf[a] = 8'hxx;
    i_rxh_host_model.send(r.ep, r.pid, r.fa, r.frm, r.iso, r.tog, r.crc,
                          r.len, r.iso ? 2 : 0);
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge mclk);
    if (n == 40) `CHK("idle", 1'b0, busy)
    repeat (3) @(posedge mclk);
  endtask

  task automatic runRow(input rxh_row_t r);
    logic [10:0] cnt;
    logic [7:0]  hx [8];
    cnt = 11'(r.len) + 11'h008;
    hx = '{{r.crc, r.tog, r.mis, 1'b0, r.ep}, {4'h0, r.pid}, {1'b0, r.fa},
           8'h00, r.frm[7:0], r.frm[15:8], cnt[7:0], {5'h00, cnt[10:8]}};
    sendWait(r);
    for (int a = 0; a < 8; a++) `CHK("header", hx[a], pbuf[a])
    `CHK("flags", hx[0], pbuf[0])
    `CHK("count", {hx[7], hx[6]}, {pbuf[7], pbuf[6]})
    for (int k = 0; k < r.len; k++)
      `CHK("payload", i_rxh_host_model.payByte(r.frm, k), pbuf[k + 8])
    `CHK("irq", irqExp, irq)
    regRead(4'h1);
    `CHK("status", {5'h00, r.mis, r.crc, 1'b1}, rd)
    `CHK("irqClr", 1'b0, irq)
    regRead(4'h3);
    `CHK("cntLo", cnt[7:0], rd)
    regRead(4'h4);
    `CHK("cntHi", {5'h00, cnt[10:8]}, rd)
  endtask

  // expected toggle flag: firmware reads it as a hint only
  rxh_row_t rows [7] = '{
    '{4'h2, 4'h3, 7'h5a, 16'hfbcd, 1'b0, 1'b1, 1'b0, 3, 1'b1},
    '{4'h2, 4'h1, 7'h01, 16'h0700, 1'b0, 1'b0, 1'b0, 0, 1'b0},
    '{4'h2, 4'h9, 7'h40, 16'h0001, 1'b0, 1'b0, 1'b0, 1, 1'b1},
    '{4'h2, 4'h3, 7'h22, 16'h8000, 1'b0, 1'b1, 1'b1, 2, 1'b0},
    '{4'h2, 4'hb, 7'h33, 16'h07ff, 1'b0, 1'b0, 1'b0, 5, 1'b1},
    '{4'h5, 4'h1, 7'h11, 16'h1234, 1'b1, 1'b1, 1'b0, 4, 1'b0},
    '{4'hf, 4'hf, 7'h7f, 16'hffff, 1'b0, 1'b0, 1'b0, 2, 1'b0}};

  // ==========================================================
  // main sequence
  initial begin
    {rst, regWr, regRd, regAddr, regWrData} = {1'b1, 14'h0000};
    {irqExp, cycles, miscompares, totalChecks} = '0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    `CHK("busyRst", 1'b0, busy)
    `CHK("irqRst", 1'b0, irq)
    regRead(4'h0);
    `CHK("ctrlRst", 8'h01, rd)
    regRead(4'h2);
    `CHK("maskRst", 8'h00, rd)
    regWrite(4'hf, 8'h00);
    regRead(4'hf);
    `CHK("unmapped", 8'h00, rd)
    regRead(4'h0);
    `CHK("ctrlKept", 8'h01, rd)
    regWrite(4'h2, 8'h01);
    irqExp = 1'b1;
    foreach (rows[i]) runRow(rows[i]);
    // masked: status stays pending until the mask opens
    regWrite(4'h2, 8'h00);
    irqExp = 1'b0;
    sendWait(rows[6]);
    `CHK("irqMasked", 1'b0, irq)
    regWrite(4'h2, 8'h01);
    #1 `CHK("irqOpen", 1'b1, irq)
    // toggle clear: endpoint two restarts from one
    regWrite(4'h0, 8'h03);
    irqExp = 1'b1;
    runRow('{4'h2, 4'h3, 7'h05, 16'h0010, 1'b0, 1'b1, 1'b0, 1, 1'b1});
    // disabled writer ignores packet start
    regWrite(4'h0, 8'h00);
    i_rxh_host_model.send(4'h1, 4'h1, 7'h01, 16'h0000, 1'b0, 1'b0, 1'b0,
                          2, 0);
    `CHK("busyOff", 1'b0, busy)
    regWrite(4'h0, 8'h01);
    // overrun: one byte beyond the largest payload
    sendWait('{4'h3, 4'h1, 7'h02, 16'h0042, 1'b0, 1'b1, 1'b0, 1281, 1'b0});
    regRead(4'h1);
    `CHK("overrun", 1'b1, rd[3])
    reportAndStop();
  end
endmodule // rxh_header_writer_tb_top

`default_nettype wire

// [rxh_host_model.sv]
// rxh_host_model.sv: far-side packet source for the header writer bench.
// assumes: the bench calls send() for one packet at a time, after reset.
`timescale 1ns/1ps
`default_nettype none

module rxh_host_model (
  // clock
  input  wire logic        mclk,
  // packet side
  output logic             pktStart,
  output logic      [3:0]  pktEndpoint,
  output logic      [3:0]  pktPid,
  output logic      [6:0]  receivedFunctionAddress,
  output logic      [15:0] pktFrame,
  output logic             pktIso,
  output logic             rxValid,
  output logic      [7:0]  rxData,
  output logic             pktEnd,
  output logic             pktCrcErr,
  output logic             receivedToggleBit
);
  // ==========================================================
  // packet source
  initial begin
    {pktStart, pktEndpoint, pktPid, receivedFunctionAddress, pktFrame,
     pktIso, rxValid, rxData, pktEnd, pktCrcErr, receivedToggleBit} = '0;
  end

  function automatic logic [7:0] payByte(input logic [15:0] f, input int k);
    return f[7:0] ^ 8'(k * 7);
  endfunction

  // gap adds idle cycles between bytes for a slow sender
  task automatic send(input logic [3:0] ep, input logic [3:0] pid,
                      input logic [6:0] fa, input logic [15:0] frm,
                      input logic iso, input logic tog, input logic crc,
                      input int len, input int gap);
    @(posedge mclk);
    pktStart <= 1'b1;
    {pktEndpoint, pktPid, receivedFunctionAddress, pktFrame, pktIso} <=
      {ep, pid, fa, frm, iso};
    @(posedge mclk);
    pktStart <= 1'b0;
    // released fields show inverted values, not the stale ones
    {pktEndpoint, pktPid, receivedFunctionAddress, pktFrame, pktIso} <=
      ~{ep, pid, fa, frm, iso};
    for (int k = 0; k < len; k++) begin
      rxValid <= 1'b1;
      rxData  <= payByte(frm, k);
      @(posedge mclk);
      if (gap > 0) begin
        rxValid <= 1'b0;
        rxData  <= ~rxData;
        repeat (gap) @(posedge mclk);
      end
    end
    rxValid           <= 1'b0;
    rxData            <= ~rxData;
    pktEnd            <= 1'b1;
    pktCrcErr         <= crc;
    receivedToggleBit <= tog;
    @(posedge mclk);
    pktEnd            <= 1'b0;
    pktCrcErr         <= ~crc;
    receivedToggleBit <= ~tog;
  endtask
endmodule // rxh_host_model

`default_nettype wire

// [rxh_pkg.sv]
// rxh_pkg.sv: types shared by the receive packet header writer.
// assumes: rxh_regs.svh supplies the numeric constants.
`default_nettype none

package rxh_pkg;

  // ==========================================================
  // writer sequence
  typedef enum logic [3:0] {
    RXH_IDLE = 4'b0001,
    RXH_PAY  = 4'b0010,
    RXH_SIEH = 4'b0100,
    RXH_DMAH = 4'b1000
  } rxh_state_t;

  typedef logic [10:0] rxh_ofs_t;

endpackage

`default_nettype wire

// [rxh_regs.svh]
// rxh_regs.svh: offsets, field positions, reset values and counts for the
// receive packet header writer.
// assumes: included by bare name; defines only, no logic.
//
// Overview of operation
// [R01] eight header bytes sit at buffer offsets zero to seven, before payload
// [R02] payload bytes are stored in order from offset eight to size plus seven
// [R03] serial engine writes bytes 0-5: endpoint, packet id, function address
// [R04] bytes four and five hold the sixteen-bit frame count; byte three reserved
// [R05] the packet DMA engine writes bytes six and seven after storage
// [R06] eleven-bit byte count: low byte in six, bits 10:8 in seven
// [R07] bit five of byte zero flags an unexpected data toggle
// [R08] flag is one when current toggle equals previous toggle, else zero
// [R09] isochronous packets never set the toggle mismatch flag
// [R10] bit six of byte zero holds the toggle received with the packet
// [R11] bit seven of byte zero is set on a CRC error, else clear
// [R12] firmware treats a toggle mismatch as possible resend, not sure error
// [R13] byte count equals payload length plus eight, header included; code holds it at CNT_MAX for payloads over MAX_PAYLOAD
`ifndef RXH_REGS_SVH
`define RXH_REGS_SVH

// header layout
`define RXH_HDR_LEN     11'h008
`define RXH_OFS_STAT    3'h0
`define RXH_OFS_PID     3'h1
`define RXH_OFS_ADDR    3'h2
`define RXH_OFS_RSVD    3'h3
`define RXH_OFS_FRMLO   3'h4
`define RXH_OFS_FRMHI   3'h5
`define RXH_OFS_CNTLO   3'h6
`define RXH_OFS_CNTHI   3'h7
`define RXH_B0_CRC      7
`define RXH_B0_TOG      6
`define RXH_B0_MIS      5
`define RXH_RSVD_VAL    8'h00
`define RXH_TOG_RST     1'b1

// register offsets
`define RXH_REG_CTRL    4'h0
`define RXH_REG_STAT    4'h1
`define RXH_REG_MASK    4'h2
`define RXH_REG_CNTLO   4'h3
`define RXH_REG_CNTHI   4'h4

// control bits and reset values
`define RXH_CTRL_EN     0
`define RXH_CTRL_TCLR   1
`define RXH_CTRL_RST    8'h01
`define RXH_MASK_RST    4'h0

// status bits
`define RXH_ST_DONE     0
`define RXH_ST_CRC      1
`define RXH_ST_MIS      2
`define RXH_ST_OVR      3

`endif
